// [hdl/pin_mux_consts.svh]
/*
 Register offsets, reset values and field positions of the peripheral
 pin mux. Assumes nothing; definitions only.
*/
`ifndef PIN_MUX_CONSTS_SVH
`define PIN_MUX_CONSTS_SVH

`define ADDR_PORT0_DATA 8'h80
`define ADDR_PORT1_DATA 8'h90
`define ADDR_PORT2_DATA 8'hA0
`define ADDR_LOC_SELECT 8'hF1
`define ADDR_ADC_MASK 8'hF2
`define ADDR_PORT0_SEL 8'hF3
`define ADDR_PORT1_SEL 8'hF4
`define ADDR_PORT2_SEL 8'hF5
`define ADDR_PORT0_DIR 8'hFD
`define ADDR_PORT1_DIR 8'hFE
`define ADDR_PORT2_DIR 8'hFF

`define RST_PORT01_DATA 8'hFF
`define RST_PORT2_DATA 8'h1F
`define RST_CONFIG 8'h00

`define MASK_PORT2_DATA 8'h1F
`define MASK_LOC_SELECT 8'h73
`define MASK_PORT2_SEL 8'h7F
`define MASK_PORT2_DIR 8'hDF

`define LOC_TIMER_ONE 6
`define LOC_TIMER_THREE 5
`define LOC_TIMER_FOUR 4
`define LOC_SERIAL_TWO 1
`define LOC_SERIAL_ONE 0

`define PRI_PORT1_BIT3 6
`define PRI_PORT1_BIT2 5
`define PRI_PORT1_BIT1 4
`define PRI_PORT1_BIT0 3
`define PRI_PORT0_MSB 7
`define PRI_PORT0_LSB 6

`endif

// [hdl/pin_mux_pkg.sv]
/*
 Types of the peripheral pin mux: pin owners and the register state.
 Assumes the constants header is compiled alongside.
*/
package pin_mux_pkg;
   typedef enum logic [2:0] {
      own_gpio, own_ser1, own_ser2, own_tmr1, own_tmr3, own_tmr4
   } owner_t;

   typedef struct packed {
      logic [1:0][7:0] data;
      logic [4:0] data2;
      logic [7:0] loc;
      logic [7:0] adc_mask;
      logic [1:0][7:0] sel;
      logic [7:0] sel2;
      logic [1:0][7:0] dir;
      logic [7:0] dir2;
      logic [7:0] rdata;
      logic [1:0][7:0] pin;
      logic [1:0][7:0] oe_n;
      logic [4:0] pin2;
      logic [4:0] oe2_n;
      logic [7:0] analog;
      logic xosc;
      logic [3:0] ser1_rx;
      logic [3:0] ser2_rx;
      logic [2:0] tmr1_cap;
      logic trig;
      logic dbg_data;
      logic dbg_clk;
   } state_t;
endpackage : pin_mux_pkg

// [hdl/peripheral_pin_mux.sv]
/*
 Peripheral pin mux: routes serial units, timers, ADC, debug, crystal and
 radio test signals onto ports 0-2 and holds their select registers.
 Assumes a byte-wide register port driven synchronously to clk_sys_in and
 pad cells that resolve each pin from its value and active-low enable.
*/
// What this block does
// - timer-1 location bit picks port0 bits 2-4 or port1 bits 2-0.
// - timer-3 location bit picks port1 bits 3,4 or bits 6,7.
// - timer-4 location bit picks port1 bits 0,1 or port2 bits 0,3.
// - serial-one uart location bit picks port0 2-5 or port1 4,5,2,3.
// - serial-one spi uses the same two pin sets as its uart.
// - serial-two uart location bit picks port0 2-5 or port1 4-7.
// - serial-two spi uses the same two pin sets as its uart.
// - port0 priority field: 00 serial one, 01 serial two, else timer 1.
// - serial one without flow control frees port0 bits 4 and 5.
// - serial two without flow control frees port0 bits 2 and 3.
// - port1: serial one wins when priority bits 3, 2 and 0 are low.
// - port1: serial two wins when bit 3 is high and bit 2 low.
// - port1: timer 1 wins when bit 1 is low and bit 0 high.
// - port1: timer 3 beats a conflicting serial unit when bit 2 set.
// - port1: timer 4 beats timer 1 when bit 1 is set.
// - serial one without flow control frees port1 bits 2 and 3.
// - serial two without flow control frees port1 bits 4 and 5.
// - adc mask bit makes a port0 pin analog, over its select bit.
// - debug mode owns port2 bits 1,2; data driven only when returning.
// - slow-clock bit low hands port2 bits 3,4 to crystal, analog.
// - radio test mode forces port1 bits 4-7 out with status flags.
// - a port0/port1 pin is driven by its peripheral only when its select bit is 1; unit inputs always follow the pads.
// - a gpio pin drives when its direction bit is 1.
`include "pin_mux_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module peripheral_pin_mux (
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   input wire logic [7:0] sfr_addr_in,
   input wire logic sfr_wr_in,
   input wire logic [7:0] sfr_wdata_in,
   output logic [7:0] sfr_rdata_out,
   input wire logic [7:0] port0_pin_in,
   output logic [7:0] port0_pin_out,
   output logic [7:0] port0_oe_n_out,
   input wire logic [7:0] port1_pin_in,
   output logic [7:0] port1_pin_out,
   output logic [7:0] port1_oe_n_out,
   input wire logic [4:0] port2_pin_in,
   output logic [4:0] port2_pin_out,
   output logic [4:0] port2_oe_n_out,
   output logic [7:0] adc_input_out,
   output logic xosc_pins_analog_out,
   input wire logic slow_clock_source_bit_in,
   input wire logic [3:0] serial_one_sig_in,
   input wire logic serial_one_spi_in,
   input wire logic serial_one_master_in,
   input wire logic serial_one_flow_in,
   output logic [3:0] serial_one_pin_out,
   input wire logic [3:0] serial_two_sig_in,
   input wire logic serial_two_spi_in,
   input wire logic serial_two_master_in,
   input wire logic serial_two_flow_in,
   output logic [3:0] serial_two_pin_out,
   input wire logic [2:0] timer_one_ch_in,
   output logic [2:0] timer_one_cap_out,
   input wire logic [1:0] timer_three_ch_in,
   input wire logic [1:0] timer_four_ch_in,
   output logic adc_trigger_out,
   input wire logic debug_active_in,
   input wire logic debug_data_drive_in,
   input wire logic debug_data_line_in,
   output logic debug_data_line_out,
   output logic debug_clock_line_out,
   input wire logic radio_test_sel_in,
   input wire logic [3:0] radio_status_flags_in
);
   import pin_mux_pkg::*;

   state_t q;
   state_t next_q;

   // serial pin for canonical index: 0 rx/miso, 1 tx/mosi, 2 cts/ss, 3 rts/sck
   function automatic logic [2:0] ser_pin(input logic two, input logic loc,
                                          input logic [1:0] j);
      logic [2:0] p;
      p = 3'(j) + 3'h2;
      if (!two && loc)
         p = j[1] ? {2'b01, j[0]} : {2'b10, j[0]};
      else if (two && !loc)
         p = j[1] ? {2'b01, j[0]} : {2'b10, ~j[0]};
      else if (two && loc)
         p = j[1] ? {2'b10, j[0]} : {2'b11, ~j[0]};
      return p;
   endfunction : ser_pin

   // {claims, index} of owner o on pin p of port k (0 or 1)
   function automatic logic [2:0] role(input logic k, input logic [2:0] p,
                                       input owner_t o, input logic [7:0] loc,
                                       input logic [1:0] lean);
      logic [2:0] r;
      logic two;
      r = 3'h0;
      two = (o == own_ser2);
      unique case (o)
         own_ser1, own_ser2: begin
            for (int j = 0; j < 4; j++) begin
               if (loc[two ? `LOC_SERIAL_TWO : `LOC_SERIAL_ONE] == k &&
                   ser_pin(two, k, 2'(j)) == p && !(lean[two] && j >= 2))
                  r = {1'b1, 2'(j)};
            end
         end
         own_tmr1: begin
            if (loc[`LOC_TIMER_ONE] && k && p <= 3'h2)
               r = {1'b1, 2'(3'h2 - p)};
            else if (!loc[`LOC_TIMER_ONE] && !k && p >= 3'h2 && p <= 3'h4)
               r = {1'b1, 2'(p - 3'h2)};
         end
         own_tmr3: begin
            if (k && (p - (loc[`LOC_TIMER_THREE] ? 3'h6 : 3'h3)) <= 3'h1)
               r = {1'b1, 2'(p - (loc[`LOC_TIMER_THREE] ? 3'h6 : 3'h3))};
         end
         own_tmr4: begin
            if (!loc[`LOC_TIMER_FOUR] && k && p <= 3'h1)
               r = {1'b1, 2'(p)};
         end
         own_gpio: r = 3'h0;
      endcase
      return r;
   endfunction : role

   // does owner a take a shared pin from owner b
   function automatic logic beats(input logic k, input owner_t a,
                                  input owner_t b, input logic [1:0] f0,
                                  input logic [7:0] s2);
      logic w;
      w = 1'b0;
      if (!k) begin
         unique case (f0)
            2'b00: w = (a == own_ser1) || (a == own_ser2 && b == own_tmr1);
            2'b01: w = (a == own_ser2) || (a == own_ser1 && b == own_tmr1);
            default: w = (a == own_tmr1) || (a == own_ser2 && b == own_ser1);
         endcase
      end else if ((a == own_ser2 && b == own_ser1) ||
                   (a == own_ser1 && b == own_ser2))
         w = (a == own_ser2) == s2[`PRI_PORT1_BIT3];
      else if (a == own_tmr3 || b == own_tmr3)
         w = (a == own_tmr3) == s2[`PRI_PORT1_BIT2];
      else if (a == own_tmr4 || b == own_tmr4)
         w = (a == own_tmr4) == s2[`PRI_PORT1_BIT1];
      else
         w = (a == own_tmr1) == s2[`PRI_PORT1_BIT0];
      return w;
   endfunction : beats

   // serial direction: uart drives tx and rts, spi by role
   function automatic logic ser_drv(input logic [1:0] j, input logic spi,
                                    input logic master);
      return spi ? (master ? (j != 2'h0) : (j == 2'h0)) : j[0];
   endfunction : ser_drv

   always_comb begin
      owner_t win;
      logic [2:0] r;
      logic [1:0] lean;
      logic [1:0][7:0] pins_in;
      logic drv;
      logic val;
      win = own_gpio;
      r = 3'h0;
      drv = 1'b0;
      val = 1'b0;
      lean = {!serial_two_spi_in && !serial_two_flow_in,
              !serial_one_spi_in && !serial_one_flow_in};
      pins_in = {port1_pin_in, port0_pin_in};
      next_q = q;
      if (sfr_wr_in) begin
         unique case (sfr_addr_in)
            `ADDR_PORT0_DATA: next_q.data[0] = sfr_wdata_in;
            `ADDR_PORT1_DATA: next_q.data[1] = sfr_wdata_in;
            `ADDR_PORT2_DATA: next_q.data2 = sfr_wdata_in[4:0];
            `ADDR_LOC_SELECT: next_q.loc = sfr_wdata_in & `MASK_LOC_SELECT;
            `ADDR_ADC_MASK: next_q.adc_mask = sfr_wdata_in;
            `ADDR_PORT0_SEL: next_q.sel[0] = sfr_wdata_in;
            `ADDR_PORT1_SEL: next_q.sel[1] = sfr_wdata_in;
            `ADDR_PORT2_SEL: next_q.sel2 = sfr_wdata_in & `MASK_PORT2_SEL;
            `ADDR_PORT0_DIR: next_q.dir[0] = sfr_wdata_in;
            `ADDR_PORT1_DIR: next_q.dir[1] = sfr_wdata_in;
            `ADDR_PORT2_DIR: next_q.dir2 = sfr_wdata_in & `MASK_PORT2_DIR;
            default: next_q.rdata = q.rdata;
         endcase
      end
      // port data reads return pin levels, not the output latch
      unique case (sfr_addr_in)
         `ADDR_PORT0_DATA: next_q.rdata = port0_pin_in;
         `ADDR_PORT1_DATA: next_q.rdata = port1_pin_in;
         `ADDR_PORT2_DATA: next_q.rdata = {3'h0, port2_pin_in};
         `ADDR_LOC_SELECT: next_q.rdata = q.loc;
         `ADDR_ADC_MASK: next_q.rdata = q.adc_mask;
         `ADDR_PORT0_SEL: next_q.rdata = q.sel[0];
         `ADDR_PORT1_SEL: next_q.rdata = q.sel[1];
         `ADDR_PORT2_SEL: next_q.rdata = q.sel2;
         `ADDR_PORT0_DIR: next_q.rdata = q.dir[0];
         `ADDR_PORT1_DIR: next_q.rdata = q.dir[1];
         `ADDR_PORT2_DIR: next_q.rdata = q.dir2;
         default: next_q.rdata = 8'h00;
      endcase
      for (int k = 0; k < 2; k++) begin
         for (int p = 0; p < 8; p++) begin
            win = own_gpio;
            for (int o = 1; o < 6; o++) begin
               if (role(k[0], 3'(p), owner_t'(3'(o)), q.loc, lean) >= 3'h4 &&
                   (win == own_gpio ||
                    beats(k[0], owner_t'(3'(o)), win,
                          q.dir2[`PRI_PORT0_MSB:`PRI_PORT0_LSB], q.sel2)))
                  win = owner_t'(3'(o));
            end
            if (!q.sel[k][p])
               win = own_gpio;
            r = role(k[0], 3'(p), win, q.loc, lean);
            unique case (win)
               own_ser1: begin
                  val = serial_one_sig_in[r[1:0]];
                  drv = ser_drv(r[1:0], serial_one_spi_in, serial_one_master_in);
               end
               own_ser2: begin
                  val = serial_two_sig_in[r[1:0]];
                  drv = ser_drv(r[1:0], serial_two_spi_in, serial_two_master_in);
               end
               own_tmr1: begin
                  val = timer_one_ch_in[r[1:0]];
                  drv = q.dir[k][p];
               end
               own_tmr3: begin
                  val = timer_three_ch_in[r[0]];
                  drv = q.dir[k][p];
               end
               own_tmr4: begin
                  val = timer_four_ch_in[r[0]];
                  drv = q.dir[k][p];
               end
               own_gpio: begin
                  val = q.data[k][p];
                  drv = q.dir[k][p];
               end
            endcase
            if (k == 0 && q.adc_mask[p])
               drv = 1'b0;
            if (k == 1 && p >= 4 && radio_test_sel_in) begin
               val = radio_status_flags_in[p - 4];
               drv = 1'b1;
            end
            next_q.pin[k][p] = val;
            next_q.oe_n[k][p] = !drv;
         end
      end
      next_q.analog = q.adc_mask;
      // port2: timer 4 alternate, debug pair, crystal pair
      for (int p = 0; p < 5; p++) begin
         next_q.pin2[p] = q.data2[p];
         next_q.oe2_n[p] = !q.dir2[p];
      end
      if (q.loc[`LOC_TIMER_FOUR] && q.sel2[0]) begin
         next_q.pin2[0] = timer_four_ch_in[0];
         next_q.oe2_n[0] = !q.dir2[0];
      end
      if (q.loc[`LOC_TIMER_FOUR] && q.sel2[1]) begin
         next_q.pin2[3] = timer_four_ch_in[1];
         next_q.oe2_n[3] = !q.dir2[3];
      end
      if (debug_active_in) begin
         next_q.pin2[1] = debug_data_line_in;
         next_q.oe2_n[1] = !debug_data_drive_in;
         next_q.pin2[2] = 1'b0;
         next_q.oe2_n[2] = 1'b1;
      end
      next_q.xosc = !slow_clock_source_bit_in;
      if (!slow_clock_source_bit_in)
         next_q.oe2_n[4:3] = 2'b11;
      for (int j = 0; j < 4; j++) begin
         next_q.ser1_rx[j] = pins_in[q.loc[`LOC_SERIAL_ONE]]
            [ser_pin(1'b0, q.loc[`LOC_SERIAL_ONE], 2'(j))];
         next_q.ser2_rx[j] = pins_in[q.loc[`LOC_SERIAL_TWO]]
            [ser_pin(1'b1, q.loc[`LOC_SERIAL_TWO], 2'(j))];
      end
      for (int j = 0; j < 3; j++)
         next_q.tmr1_cap[j] = q.loc[`LOC_TIMER_ONE] ? port1_pin_in[2 - j]
                                                     : port0_pin_in[2 + j];
      // trigger is only meaningful while software keeps bit 0 a gpio input
      next_q.trig = port2_pin_in[0];
      next_q.dbg_data = port2_pin_in[1];
      next_q.dbg_clk = port2_pin_in[2];
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         q <= '{data: {`RST_PORT01_DATA, `RST_PORT01_DATA},
                data2: 5'(`RST_PORT2_DATA), oe_n: 16'hFFFF, oe2_n: 5'h1F,
                default: '0};
      end else begin
         q <= next_q;
      end
   end

   assign sfr_rdata_out = q.rdata;
   assign port0_pin_out = q.pin[0];
   assign port0_oe_n_out = q.oe_n[0];
   assign port1_pin_out = q.pin[1];
   assign port1_oe_n_out = q.oe_n[1];
   assign port2_pin_out = q.pin2;
   assign port2_oe_n_out = q.oe2_n;
   assign adc_input_out = q.analog;
   assign xosc_pins_analog_out = q.xosc;
   assign serial_one_pin_out = q.ser1_rx;
   assign serial_two_pin_out = q.ser2_rx;
   assign timer_one_cap_out = q.tmr1_cap;
   assign adc_trigger_out = q.trig;
   assign debug_data_line_out = q.dbg_data;
   assign debug_clock_line_out = q.dbg_clk;

   xosc_hand_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      !slow_clock_source_bit_in |=> xosc_pins_analog_out && port2_oe_n_out[4:3] == 2'b11)
      else $error("crystal pins not released to oscillator");
   radio_force_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      radio_test_sel_in |=> port1_oe_n_out[7:4] == 4'h0 &&
         port1_pin_out[7:4] == $past(radio_status_flags_in))
      else $error("radio test pins not forced");
   adc_mask_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      1'b1 |=> (port0_oe_n_out & $past(q.adc_mask)) == $past(q.adc_mask))
      else $error("adc pin still driven");
   gpio_dir_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      !q.sel[1][0] |=> port1_oe_n_out[0] == !$past(q.dir[1][0]))
      else $error("gpio direction wrong");
   gpio_data_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      !q.sel[1][0] && q.dir[1][0] |=> port1_pin_out[0] == $past(q.data[1][0]))
      else $error("gpio data not driven");
   debug_pins_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      debug_active_in && !debug_data_drive_in |=> port2_oe_n_out[2:1] == 2'b11)
      else $error("debug pins driven while idle");
   timer_alt_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      q.sel[1][2] && q.loc[6] && !q.loc[0] && q.dir[1][2] |=>
         port1_pin_out[2] == $past(timer_one_ch_in[0]) && !port1_oe_n_out[2])
      else $error("timer one channel 0 not on alternate pin");
   port0_prio_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      q.sel[0][3] && q.loc[1:0] == 2'b00 && q.dir2[7:6] == 2'b00 &&
         !q.adc_mask[3] && !serial_one_spi_in |=>
         port0_pin_out[3] == $past(serial_one_sig_in[1]) && !port0_oe_n_out[3])
      else $error("serial one lost port0 bit 3");
   flow_free_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      q.sel[0][4] && q.loc[1:0] == 2'b00 && q.dir2[7:6] == 2'b00 &&
         !q.adc_mask[4] && !serial_one_spi_in && !serial_one_flow_in &&
         !serial_two_spi_in |=>
         port0_pin_out[4] == $past(serial_two_sig_in[1]))
      else $error("port0 bit 4 not freed");
endmodule : peripheral_pin_mux
`default_nettype wire

// [test/peripheral_pin_mux_partner.sv]
/*
 Model of the on-chip units beside the pin mux: serial units, timers,
 radio status flags and debug data.
 Assumes the bench pulses shuffle_in whenever it wants fresh values.
*/
`timescale 1ns/1ps
`default_nettype none
module peripheral_pin_mux_partner (
   input wire logic clk_sys_in,
   input wire logic shuffle_in,
   output logic [3:0] serial_one_sig_out,
   output logic [3:0] serial_two_sig_out,
   output logic [2:0] timer_one_ch_out,
   output logic [1:0] timer_three_ch_out,
   output logic [1:0] timer_four_ch_out,
   output logic [3:0] radio_flags_out,
   output logic debug_data_out
);
   integer seed = 32'h1A09;
   logic [19:0] draw = 20'h00000;
   // new values land after the edge, never racing the mux sampling
   always @(posedge clk_sys_in) begin
      if (shuffle_in) begin
         #1 draw = 20'($random(seed));
      end
   end
   assign {debug_data_out, radio_flags_out, timer_four_ch_out} = draw[19:15];
   assign {timer_three_ch_out, timer_one_ch_out} = draw[14:10];
   assign {serial_two_sig_out, serial_one_sig_out} = draw[7:0];
endmodule : peripheral_pin_mux_partner
`default_nettype wire

// [test/peripheral_pin_mux_tb_top.sv]
/*
 Self-checking bench of the pin mux: registers, gpio, routing and
 priority table, analog, radio, crystal and debug overrides.
 Assumes the design files and the partner model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module peripheral_pin_mux_tb_top;
   logic clk = 1'h0, rstn = 1'h0, wr = 1'h0, shuf = 1'h0;
   logic slow = 1'h1, spi = 1'h0, rsel = 1'h0, dact = 1'h0, ddrv = 1'h0;
   logic [1:0] fl = 2'h3;
   logic [7:0] addr = 8'h00, wdata = 8'h00, x0 = 8'h00, x1 = 8'h00;
   logic [4:0] x2 = 5'h00;
   logic [7:0] d, rdata, p0o, p0e, p1o, p1e, adc, po, pe;
   logic [4:0] p2o, p2e;
   logic [3:0] s1, s2, s1p, s2p, flags, sx;
   logic [2:0] t1, t1c, p;
   logic [1:0] t3, t4;
   logic xosc, trig, dd, ddo, dco;
   logic [31:0] e;
   logic [14:0] all;
   integer seed = 32'h1A09;
   int miscompares = 0;
   int num_checks = 0;
   wire logic [7:0] p0 = (p0o & ~p0e) | (x0 & p0e);
   wire logic [7:0] p1 = (p1o & ~p1e) | (x1 & p1e);
   wire logic [4:0] p2 = (p2o & ~p2e) | (x2 & p2e);
   logic [7:0] cfg [8] = '{8'hF1, 8'hF2, 8'hF3, 8'hF4, 8'hF5, 8'hFD,
                           8'hFE, 8'hFF};
   logic [7:0] ro [3] = '{8'hF1, 8'hF5, 8'hFF};
   logic [7:0] mk [3] = '{8'h73, 8'h7F, 8'hDF};
   // mode,loc,priority,flow,pin,source; source indexes {t4,t3,t1,s2,s1}
   logic [31:0] tbl [24] = '{
      32'h00000331, 32'h00040337, 32'h00080339, 32'h000C034A,
      32'h00000245, 32'h00040131, 32'h10300351, 32'h10340357,
      32'h10340151, 32'h1222036B, 32'h12200365, 32'h14108328,
      32'h14100228, 32'h1010023B, 32'h1401030D, 32'h1400030A,
      32'h1000034C, 32'h1200037C, 32'h14000319, 32'h1000031E,
      32'h20000353, 32'h30100333, 32'h20040345, 32'h30200357};

   peripheral_pin_mux uut (
      .clk_sys_in(clk), .resetn_in(rstn), .sfr_addr_in(addr),
      .sfr_wr_in(wr), .sfr_wdata_in(wdata), .sfr_rdata_out(rdata),
      .port0_pin_in(p0), .port0_pin_out(p0o), .port0_oe_n_out(p0e),
      .port1_pin_in(p1), .port1_pin_out(p1o), .port1_oe_n_out(p1e),
      .port2_pin_in(p2), .port2_pin_out(p2o), .port2_oe_n_out(p2e),
      .adc_input_out(adc), .xosc_pins_analog_out(xosc),
      .slow_clock_source_bit_in(slow),
      .serial_one_sig_in(s1), .serial_one_spi_in(spi),
      .serial_one_master_in(spi), .serial_one_flow_in(fl[0]),
      .serial_one_pin_out(s1p),
      .serial_two_sig_in(s2), .serial_two_spi_in(spi),
      .serial_two_master_in(spi), .serial_two_flow_in(fl[1]),
      .serial_two_pin_out(s2p),
      .timer_one_ch_in(t1), .timer_one_cap_out(t1c),
      .timer_three_ch_in(t3), .timer_four_ch_in(t4),
      .adc_trigger_out(trig), .debug_active_in(dact),
      .debug_data_drive_in(ddrv), .debug_data_line_in(dd),
      .debug_data_line_out(ddo), .debug_clock_line_out(dco),
      .radio_test_sel_in(rsel), .radio_status_flags_in(flags));

   peripheral_pin_mux_partner far_side (
      .clk_sys_in(clk), .shuffle_in(shuf),
      .serial_one_sig_out(s1), .serial_two_sig_out(s2),
      .timer_one_ch_out(t1), .timer_three_ch_out(t3),
      .timer_four_ch_out(t4), .radio_flags_out(flags),
      .debug_data_out(dd));

   initial begin
      forever #5 clk = ~clk;
   end

   task automatic chk(input string what, input logic [7:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic wr_reg(input logic [7:0] a, v);
      @(posedge clk);
      #1;
      addr = a;
      wdata = v;
      wr = 1'h1;
      @(posedge clk);
      #1;
      wr = 1'h0;
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      #1;
      addr = a;
      repeat (2) @(posedge clk);
      #1;
      v = rdata;
   endtask : rd_reg

   // fresh unit and pad values, then room for the registered paths
   task automatic step();
      @(posedge clk);
      #1;
      shuf = 1'h1;
      x0 = 8'($random(seed));
      x1 = 8'($random(seed));
      x2 = 5'($random(seed));
      @(posedge clk);
      #1;
      shuf = 1'h0;
      repeat (3) @(posedge clk);
      #1;
   endtask : step

   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : test_done

   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      test_done();
   end

   initial begin
      repeat (8) @(posedge clk);
      #1;
      rstn = 1'h1;
      foreach (cfg[i]) begin
         rd_reg(cfg[i], d);
         chk("config reset", d, 8'h00);
      end
      rd_reg(8'h81, d);
      chk("unmapped read", d, 8'h00);
      foreach (ro[i]) begin
         wr_reg(ro[i], 8'hFF);
         rd_reg(ro[i], d);
         chk("read-only bits", d, mk[i]);
         wr_reg(ro[i], 8'h00);
      end
      $display("test registers done");
      wr_reg(8'hFD, 8'hFF);
      step();
      chk("port0 reset data", p0o, 8'hFF);
      d = 8'($random(seed));
      wr_reg(8'h80, d);
      step();
      chk("gpio out", p0o, d);
      chk("gpio enable", p0e, 8'h00);
      d = 8'($random(seed));
      wr_reg(8'hF2, d);
      step();
      chk("adc mask", adc, d);
      chk("adc pins float", p0e, d);
      wr_reg(8'hF2, 8'h00);
      wr_reg(8'hFD, 8'h00);
      step();
      rd_reg(8'h80, d);
      chk("port0 input", d, x0);
      rd_reg(8'hA0, d);
      chk("port2 input", d, {3'h0, x2});
      // trigger pin kept a plain input
      chk("adc trigger", 8'(trig), 8'(x2[0]));
      // unit-side inputs follow the pads at the default locations
      chk("serial one inputs", 8'(s1p), 8'(x0[5:2]));
      chk("serial two inputs", 8'(s2p), 8'({x0[3], x0[2], x0[4], x0[5]}));
      chk("timer one capture", 8'(t1c), 8'(x0[4:2]));
      $display("test gpio done");
      wr_reg(8'hF3, 8'hFF);
      wr_reg(8'hF4, 8'hFF);
      wr_reg(8'hFD, 8'hFF);
      wr_reg(8'hFE, 8'hFF);
      foreach (tbl[i]) begin
         e = tbl[i];
         wr_reg(8'hF1, e[27:20]);
         wr_reg(8'hFF, e[28] ? 8'h00 : e[19:12]);
         wr_reg(8'hF5, e[28] ? e[19:12] : 8'h00);
         spi = e[29];
         fl = e[9:8];
         p = e[6:4];
         sx = e[3:0];
         repeat (3) begin
            step();
            all = {t4, t3, t1, s2, s1};
            po = e[28] ? p1o : p0o;
            pe = e[28] ? p1e : p0e;
            chk("routed enable", 8'(pe[p]), 8'h00);
            chk("routed pin", 8'(po[p]), 8'(all[sx]));
         end
      end
      $display("test routing done");
      rsel = 1'h1;
      step();
      chk("radio flags", 8'(p1o[7:4]), 8'(flags));
      chk("radio enable", 8'(p1e[7:4]), 8'h00);
      rsel = 1'h0;
      wr_reg(8'hF1, 8'h10);
      wr_reg(8'hF5, 8'h03);
      wr_reg(8'hFF, 8'h09);
      step();
      chk("timer4 port2", 8'({p2e[3], p2e[0], p2o[3], p2o[0]}), 8'(t4));
      wr_reg(8'hF5, 8'h00);
      wr_reg(8'hFF, 8'h18);
      slow = 1'h0;
      step();
      chk("crystal pins", 8'({xosc, p2e[4:3]}), 8'h07);
      slow = 1'h1;
      step();
      chk("crystal released", 8'({xosc, p2e[4:3]}), 8'h00);
      wr_reg(8'hFF, 8'h06);
      dact = 1'h1;
      ddrv = 1'h1;
      step();
      chk("debug drive", 8'({p2e[2:1], p2o[1], ddo}), 8'({2'h2, dd, dd}));
      chk("debug clock", 8'(dco), 8'(x2[2]));
      ddrv = 1'h0;
      step();
      chk("debug listen", 8'({p2e[1], ddo}), 8'({1'h1, x2[1]}));
      dact = 1'h0;
      $display("test overrides done");
      test_done();
   end
endmodule : peripheral_pin_mux_tb_top
`default_nettype wire
